/* File: hw/csr_consts.svh */
// named offsets, bit positions, reset values and counts of the core register group
`ifndef CSR_CONSTS_SVH
`define CSR_CONSTS_SVH

// ---------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------------------
`define CSR_IDX_TIMER0        10'h001
`define CSR_IDX_STATUS        10'h003
`define CSR_IDX_PORT_B        10'h006
`define CSR_IDX_INTCTL        10'h00B
`define CSR_IDX_OPTIONS       10'h081
`define CSR_IDX_PIE           10'h08C

// ---------------------------------------------------------------------------
// alu_flags_and_bank_select fields
// ---------------------------------------------------------------------------
`define CSR_ST_IBS            7
`define CSR_ST_RP_HI          6
`define CSR_ST_RP_LO          5
`define CSR_ST_TO             4
`define CSR_ST_PD             3
`define CSR_ST_Z              2
`define CSR_ST_DC             1
`define CSR_ST_C              0
`define CSR_ST_RO_MASK        8'h18
`define CSR_ST_RESET          8'h18

// ---------------------------------------------------------------------------
// timer_prescaler_options fields
// ---------------------------------------------------------------------------
`define CSR_OPT_PU_DIS        7
`define CSR_OPT_INT_EDGE      6
`define CSR_OPT_T0_SRC        5
`define CSR_OPT_T0_EDGE       4
`define CSR_OPT_PS_ASSIGN     3
`define CSR_OPT_RATE_HI       2
`define CSR_OPT_RESET         8'hFF

// ---------------------------------------------------------------------------
// core_interrupt_control fields
// ---------------------------------------------------------------------------
`define CSR_IC_GEN            7
`define CSR_IC_PGEN           6
`define CSR_IC_T0IE           5
`define CSR_IC_EXTIE          4
`define CSR_IC_CHGIE          3
`define CSR_IC_T0IF           2
`define CSR_IC_EXTIF          1
`define CSR_IC_CHGIF          0
`define CSR_IC_RESET          8'h00
`define CSR_PIE_RESET         8'h00

// ---------------------------------------------------------------------------
// alu constants
// ---------------------------------------------------------------------------
`define CSR_NIBBLE_CARRY      4
`define CSR_BYTE_CARRY        8

`endif

/* File: hw/csr_pkg.sv */
// types shared by the core register group
`default_nettype none
package csr_pkg;
  // alu operation presented by the instruction execution unit
  typedef enum logic [3:0] {
    CSR_OP_PASS = 4'h0,  // move, swap, bit set/clear: no flags touched
    CSR_OP_ADD  = 4'h1,
    CSR_OP_SUB  = 4'h2,
    CSR_OP_AND  = 4'h3,
    CSR_OP_IOR  = 4'h4,
    CSR_OP_XOR  = 4'h5,
    CSR_OP_ROL  = 4'h6,
    CSR_OP_ROR  = 4'h7,
    CSR_OP_CLR  = 4'h8
  } csr_alu_op_t;
endpackage
`default_nettype wire

/* File: hw/csr_timer0.sv */
// timer0 counter with the shared prescaler and its watchdog routing
`default_nettype none
module csr_timer0 #(
  parameter int WIDTH = 8  // counter and prescaler width
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             src_sel,        // 1 = external pin
  input  wire logic             edge_sel,       // 1 = falling edge
  input  wire logic             assign_wdt,     // 1 = prescaler on watchdog
  input  wire logic [2:0]       rate,
  input  wire logic             clk_pin,
  input  wire logic             wr,             // software load
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             wdt_base_tick,  // raw watchdog time base
  output logic      [WIDTH-1:0] count,
  output logic                  ovf,            // one-cycle overflow pulse
  output logic                  wdt_tick        // scaled watchdog tick
);
  // ---------------------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------------------
  if (WIDTH != 8) begin : g_chk
    $error("csr_timer0 supports only WIDTH 8");
  end

  logic             pin_q;    // last pin level for edge detection
  logic [WIDTH-1:0] pre_q;    // prescaler counter
  logic [WIDTH-1:0] cnt_q;    // timer0 count
  logic             ovf_q;    // overflow pulse
  logic             t0_ev;    // source event for timer0
  logic             pre_ev;   // event feeding the prescaler
  logic             pre_tick; // prescaler output tick
  logic             inc;      // timer0 increment
  logic [WIDTH-1:0] mask;     // divide mask for the current rate

  // divide mask: timer ratios start at 1:2, watchdog ratios at 1:1
  function automatic logic [WIDTH-1:0] rate_mask(input logic [2:0] r, input logic wdt);
    logic [WIDTH:0] m;
    m = wdt ? ((9'h001 << r) - 9'h001) : ((9'h002 << r) - 9'h001);
    return m[WIDTH-1:0];
  endfunction

  // ---------------------------------------------------------------------------
  // event selection
  // ---------------------------------------------------------------------------
  // internal source ticks every instruction cycle; pin source on one edge
  always_comb begin
    if (src_sel) begin
      t0_ev = edge_sel ? (pin_q & ~clk_pin) : (~pin_q & clk_pin);
    end else begin
      t0_ev = 1'b1;
    end
    pre_ev   = assign_wdt ? wdt_base_tick : t0_ev;
    mask     = rate_mask(rate, assign_wdt);
    pre_tick = pre_ev & ((pre_q & mask) == mask);
    inc      = assign_wdt ? t0_ev : pre_tick;
    wdt_tick = assign_wdt ? pre_tick : wdt_base_tick;
  end

  // pin history
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_q <= clk_pin;
    end else begin
      pin_q <= clk_pin;
    end
  end

  // prescaler; a timer load clears it while it is assigned to timer0 so the first period is whole
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pre_q <= '0;
    end else if (wr && !assign_wdt) begin
      pre_q <= '0;
    end else if (pre_ev) begin
      pre_q <= pre_q + 8'h01;
    end
  end

  // counter and overflow pulse
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end else if (wr) begin
      cnt_q <= wdata;
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= inc & (cnt_q == 8'hFF);
      if (inc) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  assign count = cnt_q;
  assign ovf   = ovf_q;
endmodule
`default_nettype wire

/* File: hw/csr_regs.sv */
// core status, option and interrupt register group with apb access
//
// Local design decision: the APB register port.
`default_nettype none
`include "csr_consts.svh"
module csr_regs #(
  parameter int ADDR_W = 12  // apb byte address width
) (
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // instruction execution side
  input  wire logic                 alu_valid,        // one-cycle instruction strobe
  input  wire csr_pkg::csr_alu_op_t alu_op,
  input  wire logic [7:0]           alu_a,
  input  wire logic [7:0]           alu_b,
  input  wire logic                 alu_dest_status,  // result goes to status
  output logic      [7:0]           alu_result,
  input  wire logic                 watchdog_clear_instr,
  input  wire logic                 sleep_instr,
  input  wire logic                 watchdog_timeout,
  input  wire logic                 mem_indirect,     // access uses the pointer
  input  wire logic [6:0]           mem_direct_addr,
  input  wire logic [7:0]           mem_indirect_ptr,
  output logic      [8:0]           data_mem_addr,
  output logic                      indirect_bank_select,
  output logic      [1:0]           direct_bank_select,
  // pins and peripherals
  input  wire logic [7:0]           port_b_inputs,
  input  wire logic [7:0]           port_latch,
  output logic      [7:0]           pullup_en,
  input  wire logic                 ext_irq_pin,
  input  wire logic                 timer0_clock_pin,
  input  wire logic                 wdt_base_tick,
  output logic                      wdt_tick,
  output logic      [7:0]           timer0_count,
  input  wire logic [7:0]           periph_flags,
  output logic                      irq_req
);
  // ---------------------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------------------
  if (ADDR_W < 12 || ADDR_W > 32) begin : g_chk
    $error("csr_regs needs ADDR_W between 12 and 32");
  end

  logic [7:0]  st_q;        // alu_flags_and_bank_select
  logic [7:0]  st_d;
  logic [7:0]  opt_q;       // timer_prescaler_options
  logic [7:0]  ic_q;        // core_interrupt_control
  logic [7:0]  ic_d;
  logic [7:0]  pie_q;       // peripheral_interrupt_enables
  logic [31:0] rdata_q;     // read data captured in setup
  logic [8:0]  addr_q;      // registered data memory address
  logic [7:0]  res_q;       // registered alu result
  logic [3:0]  snap_q;      // upper port value at last port read
  logic        ext_q;       // last external pin level
  logic [7:0]  res;         // alu result
  logic        z_new;
  logic        dc_new;
  logic        c_new;
  logic [2:0]  upd;         // flags touched by the op: z, dc, c
  logic [9:0]  idx;         // word index
  logic        hit;         // address maps to a register
  logic [7:0]  rd_val;      // value read at the current index
  logic        wr_acc;      // apb write taken this edge
  logic        rd_acc;      // apb read taken this edge
  logic        t0_wr;
  logic        t0_ovf;
  logic        ext_edge;
  logic        mismatch;

  // byte lane 0 carries the whole register; only its strobe counts
  function automatic logic lane0_write(input logic [3:0] s);
    return s[0];
  endfunction

  // ---------------------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------------------
  // word index of the byte address; misaligned addresses count as unmapped
  always_comb begin
    idx = paddr[11:2];
    hit = 1'b0;
    rd_val = 8'h00;
    if (paddr[1:0] != 2'b00 || (paddr >> 12) != '0) begin
      hit = 1'b0;  // outside the map
    end else if (idx == `CSR_IDX_STATUS) begin
      hit = 1'b1;
      rd_val = st_q;
    end else if (idx == `CSR_IDX_INTCTL) begin
      hit = 1'b1;
      rd_val = ic_q;
    end else if (idx == `CSR_IDX_OPTIONS) begin
      hit = 1'b1;
      rd_val = opt_q;
    end else if (idx == `CSR_IDX_PIE) begin
      hit = 1'b1;
      rd_val = pie_q;
    end else if (idx == `CSR_IDX_TIMER0) begin
      hit = 1'b1;
      rd_val = timer0_count;
    end else if (idx == `CSR_IDX_PORT_B) begin
      hit = 1'b1;
      rd_val = port_b_inputs;
    end
  end

  // zero wait state: every access phase completes in its first cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign wr_acc  = psel & penable & pwrite & hit & lane0_write(pstrb);
  assign rd_acc  = psel & penable & ~pwrite & hit;
  assign prdata  = rdata_q;

  // read data is captured in the setup cycle so prdata is a flop output
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      rdata_q <= {24'h00_0000, rd_val};
    end
  end

  // ---------------------------------------------------------------------------
  // alu flag generation
  // ---------------------------------------------------------------------------
  // carries come straight from the 9-bit and 5-bit sums so polarity in
  // subtraction is an inverted borrow without any extra logic
  always_comb begin
    logic [8:0] sum;
    logic [4:0] nib;
    sum    = 9'h000;
    nib    = 5'h00;
    res    = alu_a;
    z_new  = 1'b0;
    dc_new = st_q[`CSR_ST_DC];
    c_new  = st_q[`CSR_ST_C];
    upd    = 3'b000;
    case (alu_op)
      csr_pkg::CSR_OP_ADD: begin
        sum    = {1'b0, alu_a} + {1'b0, alu_b};
        nib    = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
        res    = sum[7:0];
        dc_new = nib[`CSR_NIBBLE_CARRY];
        c_new  = sum[`CSR_BYTE_CARRY];
        upd    = 3'b111;
      end
      csr_pkg::CSR_OP_SUB: begin
        sum    = {1'b0, alu_a} + {1'b0, ~alu_b} + 9'h001;
        nib    = {1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} + 5'h01;
        res    = sum[7:0];
        dc_new = nib[`CSR_NIBBLE_CARRY];
        c_new  = sum[`CSR_BYTE_CARRY];
        upd    = 3'b111;
      end
      csr_pkg::CSR_OP_AND: begin
        res = alu_a & alu_b;
        upd = 3'b100;
      end
      csr_pkg::CSR_OP_IOR: begin
        res = alu_a | alu_b;
        upd = 3'b100;
      end
      csr_pkg::CSR_OP_XOR: begin
        res = alu_a ^ alu_b;
        upd = 3'b100;
      end
      csr_pkg::CSR_OP_ROL: begin
        res   = {alu_a[6:0], st_q[`CSR_ST_C]};
        c_new = alu_a[7];
        upd   = 3'b001;
      end
      csr_pkg::CSR_OP_ROR: begin
        res   = {st_q[`CSR_ST_C], alu_a[7:1]};
        c_new = alu_a[0];
        upd   = 3'b001;
      end
      csr_pkg::CSR_OP_CLR: begin
        res = 8'h00;
        upd = 3'b100;
      end
      default: begin
        res = alu_a;  // pass-through ops leave every flag alone
        upd = 3'b000;
      end
    endcase
    z_new = (res == 8'h00);
  end

  // result register handed back to the core
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      res_q <= 8'h00;
    end else if (alu_valid) begin
      res_q <= res;
    end
  end
  assign alu_result = res_q;

  // ---------------------------------------------------------------------------
  // status register
  // ---------------------------------------------------------------------------
  // order of precedence, lowest first: apb write, core write, flag update, power events
  always_comb begin
    logic [7:0] keep;
    keep = `CSR_ST_RO_MASK;
    st_d = st_q;
    if (wr_acc && idx == `CSR_IDX_STATUS) begin
      st_d = (pwdata[7:0] & ~keep) | (st_q & keep);
    end
    if (alu_valid && alu_dest_status) begin
      keep = keep | {5'b00000, {3{|upd}}};
      st_d = (res & ~keep) | (st_d & keep);
    end
    if (alu_valid) begin
      if (upd[2]) begin
        st_d[`CSR_ST_Z] = z_new;
      end
      if (upd[1]) begin
        st_d[`CSR_ST_DC] = dc_new;
      end
      if (upd[0]) begin
        st_d[`CSR_ST_C] = c_new;
      end
    end
    if (watchdog_clear_instr) begin
      st_d[`CSR_ST_TO] = 1'b1;
      st_d[`CSR_ST_PD] = 1'b1;
    end
    if (sleep_instr) begin
      st_d[`CSR_ST_TO] = 1'b1;
      st_d[`CSR_ST_PD] = 1'b0;
    end
    if (watchdog_timeout) begin
      st_d[`CSR_ST_TO] = 1'b0;
    end
  end

  // reset doubles as power-up: expiry and sleep flags read 1
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q <= `CSR_ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign indirect_bank_select = st_q[`CSR_ST_IBS];
  assign direct_bank_select   = st_q[`CSR_ST_RP_HI:`CSR_ST_RP_LO];

  // data memory address, registered: one cycle after the request
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      addr_q <= 9'h000;
    end else if (mem_indirect) begin
      addr_q <= {st_q[`CSR_ST_IBS], mem_indirect_ptr};
    end else begin
      addr_q <= {st_q[`CSR_ST_RP_HI:`CSR_ST_RP_LO], mem_direct_addr};
    end
  end
  assign data_mem_addr = addr_q;

  // ---------------------------------------------------------------------------
  // option and peripheral enable registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      opt_q <= `CSR_OPT_RESET;
    end else if (wr_acc && idx == `CSR_IDX_OPTIONS) begin
      opt_q <= pwdata[7:0];
    end
  end

  // one enable per peripheral source, bit 7 parallel port to bit 0 timer1
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pie_q <= `CSR_PIE_RESET;
    end else if (wr_acc && idx == `CSR_IDX_PIE) begin
      pie_q <= pwdata[7:0];
    end
  end

  // pull-ups follow the latch unless globally disabled
  assign pullup_en = opt_q[`CSR_OPT_PU_DIS] ? 8'h00 : port_latch;

  // ---------------------------------------------------------------------------
  // timer0 and prescaler
  // ---------------------------------------------------------------------------
  assign t0_wr = wr_acc && idx == `CSR_IDX_TIMER0;

  csr_timer0 #(
    .WIDTH (8)
  ) u_timer0 (
    .clock         (clock),
    .sys_rst       (sys_rst),
    .src_sel       (opt_q[`CSR_OPT_T0_SRC]),
    .edge_sel      (opt_q[`CSR_OPT_T0_EDGE]),
    .assign_wdt    (opt_q[`CSR_OPT_PS_ASSIGN]),
    .rate          (opt_q[`CSR_OPT_RATE_HI:0]),
    .clk_pin       (timer0_clock_pin),
    .wr            (t0_wr),
    .wdata         (pwdata[7:0]),
    .wdt_base_tick (wdt_base_tick),
    .count         (timer0_count),
    .ovf           (t0_ovf),
    .wdt_tick      (wdt_tick)
  );

  // ---------------------------------------------------------------------------
  // interrupt sources
  // ---------------------------------------------------------------------------
  // pin history and snapshot of the upper port taken on every port read
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ext_q  <= ext_irq_pin;
      snap_q <= 4'h0;
    end else begin
      ext_q <= ext_irq_pin;
      if (rd_acc && idx == `CSR_IDX_PORT_B) begin
        snap_q <= port_b_inputs[7:4];
      end
    end
  end

  assign ext_edge = opt_q[`CSR_OPT_INT_EDGE] ? (ext_irq_pin & ~ext_q)
                                              : (~ext_irq_pin & ext_q);
  // the mismatch keeps re-setting the flag until a port read resyncs it
  assign mismatch = port_b_inputs[7:4] != snap_q;

  // software writes first, hardware sets last so a set is never lost
  always_comb begin
    ic_d = ic_q;
    if (wr_acc && idx == `CSR_IDX_INTCTL) begin
      ic_d = pwdata[7:0];
    end
    if (t0_ovf) begin
      ic_d[`CSR_IC_T0IF] = 1'b1;
    end
    if (ext_edge) begin
      ic_d[`CSR_IC_EXTIF] = 1'b1;
    end
    if (mismatch) begin
      ic_d[`CSR_IC_CHGIF] = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ic_q <= `CSR_IC_RESET;
    end else begin
      ic_q <= ic_d;
    end
  end

  // request: global gate over core sources and the peripheral group
  assign irq_req = ic_q[`CSR_IC_GEN] &
                   ((ic_q[`CSR_IC_T0IE] & ic_q[`CSR_IC_T0IF]) |
                    (ic_q[`CSR_IC_EXTIE] & ic_q[`CSR_IC_EXTIF]) |
                    (ic_q[`CSR_IC_CHGIE] & ic_q[`CSR_IC_CHGIF]) |
                    (ic_q[`CSR_IC_PGEN] & |(pie_q & periph_flags)));
endmodule
`default_nettype wire

/* File: testbench/csr_regs_props.sv */
// port checker of the core status, option and interrupt register group
`default_nettype none
module csr_regs_props (
  input wire logic                 clock,
  input wire logic                 sys_rst,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pslverr,
  input wire logic                 alu_valid,
  input wire csr_pkg::csr_alu_op_t alu_op,
  input wire logic [7:0]           alu_a,
  input wire logic [7:0]           alu_b,
  input wire logic [7:0]           alu_result,
  input wire logic                 mem_indirect,
  input wire logic [6:0]           mem_direct_addr,
  input wire logic [7:0]           mem_indirect_ptr,
  input wire logic [8:0]           data_mem_addr,
  input wire logic                 indirect_bank_select,
  input wire logic [1:0]           direct_bank_select,
  input wire logic [7:0]           port_latch,
  input wire logic [7:0]           pullup_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // one clock domain, reset masks every check
  // ----
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  AST_ADD: assert property (
    alu_valid && alu_op == csr_pkg::CSR_OP_ADD |=> alu_result == 8'($past(alu_a) + $past(alu_b)))
    else $error("add result wrong");
  AST_SUB: assert property (
    alu_valid && alu_op == csr_pkg::CSR_OP_SUB |=> alu_result == 8'($past(alu_a) - $past(alu_b)))
    else $error("subtract result wrong");
  AST_CLR: assert property (
    alu_valid && alu_op == csr_pkg::CSR_OP_CLR |=> alu_result == 8'h00)
    else $error("clear result not zero");
  AST_ROT: assert property (
    alu_valid && alu_op == csr_pkg::CSR_OP_ROL |=> alu_result[7:1] == 7'($past(alu_a)))
    else $error("rotate left shifted wrong");
  AST_DIR: assert property (
    !mem_indirect |=> data_mem_addr == {$past(direct_bank_select), $past(mem_direct_addr)})
    else $error("direct bank address wrong");
  AST_IND: assert property (
    mem_indirect |=> data_mem_addr == {$past(indirect_bank_select), $past(mem_indirect_ptr)})
    else $error("indirect bank address wrong");
  AST_PU: assert property (
    pullup_en != 8'h00 |-> pullup_en == port_latch) else $error("pull-up not from latch");
  AST_ERR: assert property (
    pslverr |-> psel && penable) else $error("error outside access phase");
  cover property (alu_valid && alu_op == csr_pkg::CSR_OP_CLR);
  cover property (pslverr);
  cover property (mem_indirect && indirect_bank_select);
endmodule
bind csr_regs csr_regs_props u_props (.clock, .sys_rst, .psel, .penable, .pslverr, .alu_valid,
  .alu_op, .alu_a, .alu_b, .alu_result, .mem_indirect, .mem_direct_addr, .mem_indirect_ptr,
  .data_mem_addr, .indirect_bank_select, .direct_bank_select, .port_latch, .pullup_en);
`default_nettype wire

/* File: testbench/csr_periph_model.sv */
// peripheral sources: sticky flags raised by events, cleared by service code
`default_nettype none
module csr_periph_model (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [7:0] raise,        // one-cycle event per source
  input  wire logic [7:0] ack,          // clear from service code
  output logic      [7:0] periph_flags  // bit 7 parallel port .. bit 0 timer1
);
  timeunit 1ns;
  timeprecision 1ps;
  // a flag stays until acknowledged, as a real source would hold it
  always_ff @(posedge clock) begin
    if (sys_rst) periph_flags <= 8'h00;
    else periph_flags <= (periph_flags & ~ack) | raise;
  end
endmodule
`default_nettype wire

/* File: testbench/tb_core_status_option_interrupt_regs.sv */
// self-checking bench of the core register group
`default_nettype none
`include "csr_consts.svh"
module tb_core_status_option_interrupt_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr, alu_valid, e;
  logic        alu_dest_status, watchdog_clear_instr, sleep_instr, watchdog_timeout;
  logic        mem_indirect, indirect_bank_select, ext_irq_pin, timer0_clock_pin;
  logic        wdt_base_tick, wdt_tick, irq_req;
  logic [1:0]  direct_bank_select;
  logic [3:0]  pstrb;
  logic [6:0]  mem_direct_addr;
  logic [8:0]  data_mem_addr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  alu_a, alu_b, alu_result, mem_indirect_ptr, port_b_inputs, port_latch, q;
  logic [7:0]  pullup_en, timer0_count, periph_flags, raise;
  csr_pkg::csr_alu_op_t alu_op;
  int          err_total = 0, check_count = 0, cyc = 0;
  // rows: op, a, b, expected result, expected status
  logic [35:0] rows [9] = '{36'h10F01101A, 36'h1FF01001F, 36'h20505001F, 36'h20305FE18,
    36'h3F00F001C, 36'h68100021D, 36'h70200811C, 36'h55555001C, 36'h400010118};
  csr_regs u_dut (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .alu_valid, .alu_op, .alu_a, .alu_b, .alu_dest_status, .alu_result,
    .watchdog_clear_instr, .sleep_instr, .watchdog_timeout, .mem_indirect, .mem_direct_addr,
    .mem_indirect_ptr, .data_mem_addr, .indirect_bank_select, .direct_bank_select,
    .port_b_inputs, .port_latch, .pullup_en, .ext_irq_pin, .timer0_clock_pin, .wdt_base_tick,
    .wdt_tick, .timer0_count, .periph_flags, .irq_req);
  csr_periph_model u_periph (.clock, .sys_rst, .raise, .ack(8'h00), .periph_flags);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // ----
  // shared tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  // one apb transfer, leaving read data in q and the error flag in e
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(q, exp);
  endtask
  // one instruction strobe; result lands at the strobe's edge
  task automatic alu(input logic [3:0] op, input logic [7:0] a, input logic [7:0] b,
                     input logic d);
    @(posedge clock);
    alu_valid <= 1'b1;
    alu_op <= csr_pkg::csr_alu_op_t'(op);
    alu_a <= a;
    alu_b <= b;
    alu_dest_status <= d;
    @(posedge clock);
    alu_valid <= 1'b0;
    alu_dest_status <= 1'b0;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, far above the roughly 150 cycles of the run
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      conclude();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    {sys_rst, psel, penable, pwrite, alu_valid, alu_dest_status, e} = 7'h40;
    {watchdog_clear_instr, sleep_instr, watchdog_timeout, mem_indirect, ext_irq_pin} = 5'h00;
    {timer0_clock_pin, wdt_base_tick, paddr, pwdata, pstrb} = {46'h0, 4'hF};
    {alu_a, alu_b, mem_indirect_ptr, port_b_inputs, raise, q} = 48'h0;
    {port_latch, mem_direct_addr, alu_op} = {8'hA5, 7'h00, csr_pkg::CSR_OP_PASS};
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    rd(`CSR_IDX_STATUS, 8'h18);
    rd(`CSR_IDX_INTCTL, 8'h00);
    rd(`CSR_IDX_OPTIONS, 8'hFF);
    rd(`CSR_IDX_PIE, 8'h00);
    $display("reset values done");
    foreach (rows[i]) begin
      mem_indirect <= i[0];
      mem_direct_addr <= rows[i][30:24];
      mem_indirect_ptr <= rows[i][23:16];
      alu(rows[i][35:32], rows[i][31:24], rows[i][23:16], 1'b0);
      @(negedge clock) chk(alu_result, rows[i][15:8]);
      rd(`CSR_IDX_STATUS, rows[i][7:0]);
    end
    $display("alu rows done");
    apb(1'b0, 10'h0FF, 8'h00);
    chk({e, q}, 9'h100);
    apb(1'b1, `CSR_IDX_STATUS, 8'h07);
    rd(`CSR_IDX_STATUS, 8'h1F);
    apb(1'b1, `CSR_IDX_STATUS, 8'hE3);
    rd(`CSR_IDX_STATUS, 8'hFB);
    chk(direct_bank_select, 2'h3);
    alu(4'h8, 8'h00, 8'h00, 1'b1);
    rd(`CSR_IDX_STATUS, 8'h1F);
    foreach (rows[k]) if (k < 3) begin
      {watchdog_timeout, sleep_instr, watchdog_clear_instr} <= {k == 1, k == 0, k == 2};
      @(posedge clock) {watchdog_timeout, sleep_instr, watchdog_clear_instr} <= 3'h0;
      rd(`CSR_IDX_STATUS, k == 0 ? 8'h17 : (k == 1 ? 8'h07 : 8'h1F));
    end
    $display("status done");
    chk(pullup_en, 8'h00);
    apb(1'b1, `CSR_IDX_OPTIONS, 8'h7F);
    @(negedge clock) chk(pullup_en, 8'hA5);
    apb(1'b1, `CSR_IDX_INTCTL, 8'h90);
    ext_irq_pin <= 1'b1;
    rd(`CSR_IDX_INTCTL, 8'h92);
    chk(irq_req, 1'b1);
    apb(1'b1, `CSR_IDX_OPTIONS, 8'h3F);
    apb(1'b1, `CSR_IDX_INTCTL, 8'h00);
    ext_irq_pin <= 1'b0;
    rd(`CSR_IDX_INTCTL, 8'h02);
    apb(1'b1, `CSR_IDX_INTCTL, 8'h00);
    port_b_inputs <= 8'h50;
    rd(`CSR_IDX_INTCTL, 8'h01);
    rd(`CSR_IDX_PORT_B, 8'h50);
    apb(1'b1, `CSR_IDX_INTCTL, 8'h00);
    rd(`CSR_IDX_INTCTL, 8'h00);
    apb(1'b1, `CSR_IDX_PIE, 8'h01);
    apb(1'b1, `CSR_IDX_INTCTL, 8'hC0);
    raise <= 8'h01;
    @(posedge clock) raise <= 8'h00;
    @(negedge clock) chk(irq_req, 1'b1);
    apb(1'b1, `CSR_IDX_INTCTL, 8'h80);
    @(negedge clock) chk(irq_req, 1'b0);
    apb(1'b1, `CSR_IDX_OPTIONS, 8'h08);
    apb(1'b1, `CSR_IDX_TIMER0, 8'hFE);
    repeat (6) @(posedge clock);
    rd(`CSR_IDX_INTCTL, 8'h84);
    $display("interrupt and timer done");
    conclude();
  end
endmodule
`default_nettype wire
